// file: csr_bank_assertions.sv
`default_nettype none
module csr_bank_assertions #(
	parameter logic [15:0] DESIGN_CODE   = 16'hA5A5, // arbitrary value
	parameter logic [15:0] REVISION_CODE = 16'h0003  // arbitrary value
) (
	input wire logic        clk,
	input wire logic        rstn,
	input wire logic        cs_n,
	input wire logic        rd_n,
	input wire logic        wr_n,
	input wire logic [7:0]  addr,
	input wire logic        host_data_oe,
	input wire logic        dev_data_oe,
	input wire logic [31:0] data_level
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----
	// bus cycle checks
	// ----
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	logic rd_take;
	// read strobe seen by the device this cycle
	assign rd_take = !cs_n && !rd_n;
	chk_read_answer: assert property (rd_take |=> dev_data_oe)
		else $error("device silent during read");
	chk_oe_release: assert property (rd_n && $past(rd_n) |-> !dev_data_oe)
		else $error("device drives bus after read ended");
	chk_no_fight: assert property (!(host_data_oe && dev_data_oe))
		else $error("both ends drive the data bus");
	chk_write_hold: assert property ($fell(wr_n) |-> host_data_oe throughout (!wr_n [*3]))
		else $error("write data not held through strobe");
	chk_strobe_span: assert property ($fell(cs_n) |-> !cs_n [*3] ##1 cs_n [*2])
		else $error("strobe length or gap wrong");
	// fixed read values, checked on the word the device returns
	chk_byte_order: assert property (rd_take && addr == 8'h64 |=> data_level == 32'h87654321)
		else $error("byte order pattern wrong");
	chk_identity_value: assert property (rd_take && addr == 8'h50 |=>
		data_level == {DESIGN_CODE, REVISION_CODE})
		else $error("identity word wrong");
	chk_timer_count: assert property (rd_take && addr == 8'h90 |=> data_level == 32'h0000FFFF)
		else $error("timer count value wrong");
endmodule : csr_bank_assertions
`default_nettype wire

// file: csr_bank_device.sv
// Operation
// - registers decoded at fixed offsets 50h-B4h
// - byte order register returns 87654321h
// - upper identity half is read-only design code
// - lower identity half is read-only revision
// - eight-bit hold-off interval, ten microsecond units
// - zero interval disables hold-off, clears counter
// - waiting interrupt delivered once hold-off disabled
// - new interval applies at once, to a running hold-off as well
// - wake event interrupt bypasses hold-off
// - restart bit clears counter, self-clears
// - active bit shows interval, withholds pin
// - reserved offsets unused; host never writes them
// - dropped frame counter resets to zero
// - mac window: command plus data register
// - eeprom window: command plus data, reset zero
// - timer config resets to 0000FFFFh
// - timer count resets to 0000FFFFh
// - general pin config resets to zero
// - flow control config resets to zero
// - enable bit gates the output pin and irq_asserted, not master
// - master bit shows enabled active interrupts
`default_nettype none
module csr_bank_device #(
	parameter logic [15:0] DESIGN_CODE   = 16'hA5A5, // arbitrary value
	parameter logic [15:0] REVISION_CODE = 16'h0003, // arbitrary value
	parameter int          UNIT_CYCLES   = csr_bank_pkg::HOLDOFF_UNIT_CYC
) (
	input  wire logic        clk,
	input  wire logic        rstn,
	csr_bus_if.device        bus,
	input  wire logic [31:0] event_pulse,
	input  wire logic        frame_dropped,
	output logic [31:0]      mac_command,
	output logic [31:0]      mac_data,
	output logic [31:0]      eeprom_command,
	output logic [31:0]      eeprom_data,
	output logic             irq_asserted
);
	if (UNIT_CYCLES < 1 || UNIT_CYCLES > 65535) begin : unit_check
		$error("UNIT_CYCLES out of range");
	end
	// ---------------------------------------------------------------
	// bus decode
	// ---------------------------------------------------------------
	logic        rd_active;
	logic        wr_active;
	logic        wr_seen_reg;
	logic        wr_take;
	logic [31:0] wdata;
	assign rd_active = ~bus.cs_n & ~bus.rd_n;
	assign wr_active = ~bus.cs_n & ~bus.wr_n;
	assign wr_take   = wr_active & ~wr_seen_reg; // one write per strobe
	assign wdata     = bus.data_level;
	// a long write strobe must not repeat the side effects of a write
	always_ff @(posedge clk) begin
		if (!rstn) begin
			wr_seen_reg <= 1'b0;
		end else begin
			wr_seen_reg <= wr_active;
		end
	end
	function automatic logic wr_to(input logic take, input logic [7:0] a, input logic [7:0] off);
		return take && a == off;
	endfunction : wr_to
	// ---------------------------------------------------------------
	// plain storage registers and counters
	// ---------------------------------------------------------------
	logic [31:0] int_enable_reg;
	logic [31:0] fifo_level_reg;
	logic [31:0] receive_cfg_reg;
	logic [31:0] transmit_cfg_reg;
	logic [31:0] hardware_cfg_reg;
	logic [31:0] rx_datapath_reg;
	logic [31:0] power_mgmt_reg;
	logic [31:0] general_pin_reg;
	logic [31:0] timer_config_reg;
	logic [31:0] halfword_swap_reg;
	logic [31:0] flow_control_reg;
	// writable configuration; reserved offsets are simply not decoded
	always_ff @(posedge clk) begin
		if (!rstn) begin
			int_enable_reg    <= csr_bank_pkg::RST_ZERO;
			fifo_level_reg    <= csr_bank_pkg::RST_FIFO_LEVEL;
			receive_cfg_reg   <= csr_bank_pkg::RST_ZERO;
			transmit_cfg_reg  <= csr_bank_pkg::RST_ZERO;
			hardware_cfg_reg  <= csr_bank_pkg::RST_HARDWARE;
			rx_datapath_reg   <= csr_bank_pkg::RST_ZERO;
			power_mgmt_reg    <= csr_bank_pkg::RST_ZERO;
			general_pin_reg   <= csr_bank_pkg::RST_ZERO;
			timer_config_reg  <= csr_bank_pkg::RST_TIMER;
			halfword_swap_reg <= csr_bank_pkg::RST_ZERO;
			flow_control_reg  <= csr_bank_pkg::RST_ZERO;
			mac_command       <= csr_bank_pkg::RST_ZERO;
			mac_data          <= csr_bank_pkg::RST_ZERO;
			eeprom_command    <= csr_bank_pkg::RST_ZERO;
			eeprom_data       <= csr_bank_pkg::RST_ZERO;
		end else if (wr_take) begin
			unique case (bus.addr)
				csr_bank_pkg::OFF_INTERRUPT_EN:   int_enable_reg    <= wdata;
				csr_bank_pkg::OFF_FIFO_LEVEL_INT: fifo_level_reg    <= wdata;
				csr_bank_pkg::OFF_RECEIVE_CFG:    receive_cfg_reg   <= wdata;
				csr_bank_pkg::OFF_TRANSMIT_CFG:   transmit_cfg_reg  <= wdata;
				csr_bank_pkg::OFF_HARDWARE_CFG:   hardware_cfg_reg  <= wdata;
				csr_bank_pkg::OFF_RX_DATAPATH:    rx_datapath_reg   <= wdata;
				csr_bank_pkg::OFF_POWER_MGMT:     power_mgmt_reg    <= wdata;
				csr_bank_pkg::OFF_GENERAL_PIN:    general_pin_reg   <= wdata;
				csr_bank_pkg::OFF_TIMER_CONFIG:   timer_config_reg  <= wdata;
				csr_bank_pkg::OFF_HALFWORD_SWAP:  halfword_swap_reg <= wdata;
				csr_bank_pkg::OFF_MAC_COMMAND:    mac_command       <= wdata;
				csr_bank_pkg::OFF_MAC_DATA:       mac_data          <= wdata;
				csr_bank_pkg::OFF_FLOW_CONTROL:   flow_control_reg  <= wdata;
				csr_bank_pkg::OFF_EEPROM_COMMAND: eeprom_command    <= wdata;
				csr_bank_pkg::OFF_EEPROM_DATA:    eeprom_data       <= wdata;
				default: ;
			endcase
		end
	end
	logic [31:0] free_running_reg;
	logic [31:0] dropped_frames_reg;
	// counters wrap silently at the top; no timer engine lives here
	always_ff @(posedge clk) begin
		if (!rstn) begin
			free_running_reg   <= csr_bank_pkg::RST_ZERO;
			dropped_frames_reg <= csr_bank_pkg::RST_ZERO;
		end else begin
			free_running_reg <= free_running_reg + 32'h00000001;
			if (frame_dropped) begin
				dropped_frames_reg <= dropped_frames_reg + 32'h00000001;
			end
		end
	end
	// ---------------------------------------------------------------
	// interrupts and hold-off interval
	// ---------------------------------------------------------------
	logic [31:0] int_status_reg;
	logic [7:0]  interval_reg;
	logic        irq_enable_reg;
	logic        polarity_reg;
	logic        pushpull_reg;
	logic        master;
	logic        wake_pending;
	logic        cfg_write;
	assign cfg_write    = wr_to(wr_take, bus.addr, csr_bank_pkg::OFF_INTERRUPT_CFG);
	assign master       = |(int_status_reg & int_enable_reg);
	assign wake_pending = int_status_reg[csr_bank_pkg::WAKE_EVENT_BIT]
		& int_enable_reg[csr_bank_pkg::WAKE_EVENT_BIT];
	// sticky status: a new event wins over a same-cycle write-one clear
	always_ff @(posedge clk) begin
		if (!rstn) begin
			int_status_reg <= csr_bank_pkg::RST_ZERO;
		end else if (wr_to(wr_take, bus.addr, csr_bank_pkg::OFF_INTERRUPT_STS)) begin
			int_status_reg <= (int_status_reg & ~wdata) | event_pulse;
		end else begin
			int_status_reg <= int_status_reg | event_pulse;
		end
	end
	// writable configuration fields; restart bit is never stored
	always_ff @(posedge clk) begin
		if (!rstn) begin
			interval_reg   <= 8'h00;
			irq_enable_reg <= 1'b0;
			polarity_reg   <= 1'b0;
			pushpull_reg   <= 1'b0;
		end else if (cfg_write) begin
			interval_reg   <= wdata[csr_bank_pkg::CFG_INTERVAL_LSB +: 8];
			irq_enable_reg <= wdata[csr_bank_pkg::CFG_ENABLE_BIT];
			polarity_reg   <= wdata[csr_bank_pkg::CFG_POLARITY_BIT];
			pushpull_reg   <= wdata[csr_bank_pkg::CFG_PUSHPULL_BIT];
		end
	end
	logic [15:0] divider_reg;
	logic [7:0]  units_reg;
	logic        active_reg;
	logic        tick;
	logic        deliver;
	logic        zero_write;
	logic        restart;
	logic        deassert;
	assign tick       = divider_reg == 16'(UNIT_CYCLES - 1);
	assign zero_write = cfg_write && wdata[csr_bank_pkg::CFG_INTERVAL_LSB +: 8] == 8'h00;
	assign restart    = cfg_write && wdata[csr_bank_pkg::CFG_RESTART_BIT];
	assign deassert   = irq_asserted && !deliver && interval_reg != 8'h00;
	// wake event ignores the interval; enable bit gates the pin and irq_asserted, not master
	assign deliver    = irq_enable_reg && master && (!active_reg || wake_pending);
	// zero write beats a restart in the same write; divider restarts so units are whole
	always_ff @(posedge clk) begin
		if (!rstn) begin
			active_reg  <= 1'b0;
			units_reg   <= 8'h00;
			divider_reg <= 16'h0000;
		end else if (zero_write) begin
			active_reg  <= 1'b0;
			units_reg   <= 8'h00;
			divider_reg <= 16'h0000;
		end else if (restart || deassert) begin
			active_reg  <= 1'b1;
			units_reg   <= 8'h00;
			divider_reg <= 16'h0000;
		end else if (active_reg) begin
			divider_reg <= tick ? 16'h0000 : divider_reg + 16'h0001;
			if (tick) begin
				units_reg <= units_reg + 8'h01;
				if (units_reg + 8'h01 >= interval_reg) begin
					active_reg <= 1'b0;
				end
			end
		end
	end
	// open-drain drives low only while asserted; push-pull follows polarity
	always_ff @(posedge clk) begin
		if (!rstn) begin
			irq_asserted <= 1'b0;
			bus.irq_out  <= 1'b0;
			bus.irq_oe   <= 1'b0;
		end else begin
			irq_asserted <= deliver;
			bus.irq_out  <= pushpull_reg ? (deliver == polarity_reg) : 1'b0;
			bus.irq_oe   <= pushpull_reg | deliver;
		end
	end
	// ---------------------------------------------------------------
	// read path
	// ---------------------------------------------------------------
	logic [31:0] cfg_view;
	logic [31:0] rd_mux;
	assign cfg_view = {interval_reg, 9'h000, 1'b0, active_reg, master, 3'h0,
		irq_enable_reg, 3'h0, polarity_reg, 3'h0, pushpull_reg};
	// unmapped and reserved offsets read zero
	always_comb begin
		unique case (bus.addr)
			csr_bank_pkg::OFF_CHIP_IDENTITY:  rd_mux = {DESIGN_CODE, REVISION_CODE};
			csr_bank_pkg::OFF_INTERRUPT_CFG:  rd_mux = cfg_view;
			csr_bank_pkg::OFF_INTERRUPT_STS:  rd_mux = int_status_reg;
			csr_bank_pkg::OFF_INTERRUPT_EN:   rd_mux = int_enable_reg;
			csr_bank_pkg::OFF_BYTE_ORDER:     rd_mux = csr_bank_pkg::RST_BYTE_ORDER;
			csr_bank_pkg::OFF_FIFO_LEVEL_INT: rd_mux = fifo_level_reg;
			csr_bank_pkg::OFF_RECEIVE_CFG:    rd_mux = receive_cfg_reg;
			csr_bank_pkg::OFF_TRANSMIT_CFG:   rd_mux = transmit_cfg_reg;
			csr_bank_pkg::OFF_HARDWARE_CFG:   rd_mux = hardware_cfg_reg;
			csr_bank_pkg::OFF_RX_DATAPATH:    rd_mux = rx_datapath_reg;
			csr_bank_pkg::OFF_RX_QUEUE_INFO:  rd_mux = csr_bank_pkg::RST_ZERO;
			csr_bank_pkg::OFF_TX_QUEUE_INFO:  rd_mux = csr_bank_pkg::RST_TX_QUEUE;
			csr_bank_pkg::OFF_POWER_MGMT:     rd_mux = power_mgmt_reg;
			csr_bank_pkg::OFF_GENERAL_PIN:    rd_mux = general_pin_reg;
			csr_bank_pkg::OFF_TIMER_CONFIG:   rd_mux = timer_config_reg;
			csr_bank_pkg::OFF_TIMER_COUNT:    rd_mux = csr_bank_pkg::RST_TIMER;
			csr_bank_pkg::OFF_HALFWORD_SWAP:  rd_mux = halfword_swap_reg;
			csr_bank_pkg::OFF_FREE_RUNNING:   rd_mux = free_running_reg;
			csr_bank_pkg::OFF_DROPPED_FRAMES: rd_mux = dropped_frames_reg;
			csr_bank_pkg::OFF_MAC_COMMAND:    rd_mux = mac_command;
			csr_bank_pkg::OFF_MAC_DATA:       rd_mux = mac_data;
			csr_bank_pkg::OFF_FLOW_CONTROL:   rd_mux = flow_control_reg;
			csr_bank_pkg::OFF_EEPROM_COMMAND: rd_mux = eeprom_command;
			csr_bank_pkg::OFF_EEPROM_DATA:    rd_mux = eeprom_data;
			default:                          rd_mux = csr_bank_pkg::RST_ZERO;
		endcase
	end
	// data drives one cycle after the strobe is seen and drops one cycle after it ends
	always_ff @(posedge clk) begin
		if (!rstn) begin
			bus.dev_data    <= csr_bank_pkg::RST_ZERO;
			bus.dev_data_oe <= 1'b0;
		end else begin
			bus.dev_data_oe <= rd_active;
			if (rd_active) begin
				bus.dev_data <= rd_mux;
			end
		end
	end
endmodule : csr_bank_device
`default_nettype wire

// file: csr_bank_host.sv
`default_nettype none
module csr_bank_host (
	input  wire logic        clk,
	input  wire logic        rstn,
	csr_bus_if.host          bus,
	input  wire logic        req_valid,
	input  wire logic        req_write,
	input  wire logic [7:0]  req_addr,
	input  wire logic [31:0] req_wdata,
	output logic             req_ready,
	output logic             done,
	output logic             refused,
	output logic [31:0]      rdata,
	output logic             irq_seen
);
	typedef enum logic [2:0] {
		IDLE   = 3'b001,
		STROBE = 3'b010,
		GAP    = 3'b100
	} state_type;

	state_type state_reg;
	logic [1:0] count_reg;
	logic       is_write_reg;
	logic       bad;
	// reserved offsets and unaligned words are never put on the bus
	assign bad = csr_bank_pkg::is_reserved(req_addr) || req_addr[1:0] != 2'b00;

	// ---------------------------------------------------------------
	// bus cycle sequencer
	// ---------------------------------------------------------------
	// a gap cycle lets the device release data before the next strobe
	always_ff @(posedge clk) begin
		if (!rstn) begin
			state_reg        <= IDLE;
			count_reg        <= 2'd0;
			is_write_reg     <= 1'b0;
			req_ready        <= 1'b1;
			done             <= 1'b0;
			refused          <= 1'b0;
			rdata            <= 32'h00000000;
			bus.cs_n         <= 1'b1;
			bus.rd_n         <= 1'b1;
			bus.wr_n         <= 1'b1;
			bus.addr         <= 8'h00;
			bus.host_data    <= 32'h00000000;
			bus.host_data_oe <= 1'b0;
		end else begin
			done    <= 1'b0;
			refused <= 1'b0;
			unique case (state_reg)
				IDLE: begin
					if (req_valid && bad) begin
						refused <= 1'b1;
						done    <= 1'b1;
					end else if (req_valid) begin
						state_reg        <= STROBE;
						req_ready        <= 1'b0;
						count_reg        <= 2'd0;
						is_write_reg     <= req_write;
						bus.cs_n         <= 1'b0;
						bus.rd_n         <= req_write;
						bus.wr_n         <= ~req_write;
						bus.addr         <= req_addr;
						bus.host_data    <= req_wdata;
						bus.host_data_oe <= req_write;
					end
				end
				STROBE: begin
					count_reg <= count_reg + 2'd1;
					if (count_reg == 2'(csr_bank_pkg::STROBE_CYCLES - 1)) begin
						state_reg        <= GAP;
						bus.cs_n         <= 1'b1;
						bus.rd_n         <= 1'b1;
						bus.wr_n         <= 1'b1;
						bus.host_data_oe <= 1'b0;
						if (!is_write_reg) begin
							rdata <= bus.data_level;
						end
					end
				end
				GAP: begin
					state_reg <= IDLE;
					req_ready <= 1'b1;
					done      <= 1'b1;
				end
				default: state_reg <= IDLE;
			endcase
		end
	end

	// irq as the host sees it, active low on the open-drain default
	always_ff @(posedge clk) begin
		if (!rstn) begin
			irq_seen <= 1'b0;
		end else begin
			irq_seen <= ~bus.irq_level;
		end
	end
endmodule : csr_bank_host
`default_nettype wire

// file: csr_bank_pkg.sv
`default_nettype none
package csr_bank_pkg;
	// ---------------------------------------------------------------
	// register offsets (byte addresses from the base)
	// ---------------------------------------------------------------
	localparam logic [7:0] OFF_CHIP_IDENTITY  = 8'h50;
	localparam logic [7:0] OFF_INTERRUPT_CFG  = 8'h54;
	localparam logic [7:0] OFF_INTERRUPT_STS  = 8'h58;
	localparam logic [7:0] OFF_INTERRUPT_EN   = 8'h5C;
	localparam logic [7:0] OFF_RESERVED_A     = 8'h60;
	localparam logic [7:0] OFF_BYTE_ORDER     = 8'h64;
	localparam logic [7:0] OFF_FIFO_LEVEL_INT = 8'h68;
	localparam logic [7:0] OFF_RECEIVE_CFG    = 8'h6C;
	localparam logic [7:0] OFF_TRANSMIT_CFG   = 8'h70;
	localparam logic [7:0] OFF_HARDWARE_CFG   = 8'h74;
	localparam logic [7:0] OFF_RX_DATAPATH    = 8'h78;
	localparam logic [7:0] OFF_RX_QUEUE_INFO  = 8'h7C;
	localparam logic [7:0] OFF_TX_QUEUE_INFO  = 8'h80;
	localparam logic [7:0] OFF_POWER_MGMT     = 8'h84;
	localparam logic [7:0] OFF_GENERAL_PIN    = 8'h88;
	localparam logic [7:0] OFF_TIMER_CONFIG   = 8'h8C;
	localparam logic [7:0] OFF_TIMER_COUNT    = 8'h90;
	localparam logic [7:0] OFF_RESERVED_B     = 8'h94;
	localparam logic [7:0] OFF_HALFWORD_SWAP  = 8'h98;
	localparam logic [7:0] OFF_FREE_RUNNING   = 8'h9C;
	localparam logic [7:0] OFF_DROPPED_FRAMES = 8'hA0;
	localparam logic [7:0] OFF_MAC_COMMAND    = 8'hA4;
	localparam logic [7:0] OFF_MAC_DATA       = 8'hA8;
	localparam logic [7:0] OFF_FLOW_CONTROL   = 8'hAC;
	localparam logic [7:0] OFF_EEPROM_COMMAND = 8'hB0;
	localparam logic [7:0] OFF_EEPROM_DATA    = 8'hB4;
	localparam logic [7:0] OFF_RESERVED_UPPER = 8'hB8;
	// ---------------------------------------------------------------
	// reset values
	// ---------------------------------------------------------------
	localparam logic [31:0] RST_ZERO        = 32'h00000000;
	localparam logic [31:0] RST_BYTE_ORDER  = 32'h87654321;
	localparam logic [31:0] RST_FIFO_LEVEL  = 32'h48000000;
	localparam logic [31:0] RST_HARDWARE    = 32'h00050000;
	localparam logic [31:0] RST_TX_QUEUE    = 32'h00001200;
	localparam logic [31:0] RST_TIMER       = 32'h0000FFFF;
	// ---------------------------------------------------------------
	// interrupt configuration fields
	// ---------------------------------------------------------------
	localparam int CFG_INTERVAL_LSB = 24;
	localparam int CFG_RESTART_BIT  = 14;
	localparam int CFG_ACTIVE_BIT   = 13;
	localparam int CFG_MASTER_BIT   = 12;
	localparam int CFG_ENABLE_BIT   = 8;
	localparam int CFG_POLARITY_BIT = 4;
	localparam int CFG_PUSHPULL_BIT = 0;
	localparam int WAKE_EVENT_BIT   = 17;
	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int CLK_HZ           = 50_000_000;
	localparam int HOLDOFF_UNIT_US  = 10;
	localparam int HOLDOFF_UNIT_CYC = CLK_HZ / 1_000_000 * HOLDOFF_UNIT_US;
	localparam int STROBE_CYCLES    = 3;
	// is an offset one the host must leave alone
	function automatic logic is_reserved(input logic [7:0] off);
		return off == OFF_RESERVED_A || off == OFF_RESERVED_B || off >= OFF_RESERVED_UPPER;
	endfunction : is_reserved
endpackage : csr_bank_pkg
`default_nettype wire

// file: csr_bus_if.sv
`default_nettype none
interface csr_bus_if;
	logic        cs_n;
	logic        rd_n;
	logic        wr_n;
	logic [7:0]  addr;
	logic [31:0] host_data;
	logic        host_data_oe;
	logic [31:0] dev_data;
	logic        dev_data_oe;
	logic        irq_out;
	logic        irq_oe;
	logic [31:0] data_level;
	logic        irq_level;
	// wire resolution: undriven data reads zero, open-drain irq pulls high
	assign data_level = host_data_oe ? host_data : (dev_data_oe ? dev_data : 32'h00000000);
	assign irq_level  = irq_oe ? irq_out : 1'b1;
	modport device (input cs_n, rd_n, wr_n, addr, data_level,
		output dev_data, dev_data_oe, irq_out, irq_oe);
	modport host (output cs_n, rd_n, wr_n, addr, host_data, host_data_oe,
		input data_level, irq_level);
endinterface : csr_bus_if
`default_nettype wire

// file: host_csr_bank_irq_holdoff_test.sv
`default_nettype none
module host_csr_bank_irq_holdoff_test;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [15:0] ID_HI = 16'hA5A5; // arbitrary value
	localparam logic [15:0] ID_LO = 16'h0003; // arbitrary value
	logic        clk, rstn, frame_dropped, req_valid, req_write, req_ready, done, refused;
	logic        irq_seen, irq_asserted, got_refused;
	logic [7:0]  req_addr;
	logic [31:0] event_pulse, req_wdata, rdata, mac_command, mac_data, eeprom_command, eeprom_data;
	int          err_total;
	int          checks_done;
	csr_bus_if bus_if ();
	csr_bank_device #(.DESIGN_CODE(ID_HI), .REVISION_CODE(ID_LO), .UNIT_CYCLES(4)) u_csr_bank_device (
		.clk(clk), .rstn(rstn), .bus(bus_if), .event_pulse(event_pulse),
		.frame_dropped(frame_dropped), .mac_command(mac_command), .mac_data(mac_data),
		.eeprom_command(eeprom_command), .eeprom_data(eeprom_data), .irq_asserted(irq_asserted));
	csr_bank_host u_csr_bank_host (.clk(clk), .rstn(rstn), .bus(bus_if), .req_valid(req_valid),
		.req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
		.done(done), .refused(refused), .rdata(rdata), .irq_seen(irq_seen));
	csr_bank_assertions #(.DESIGN_CODE(ID_HI), .REVISION_CODE(ID_LO)) u_csr_bank_assertions (
		.clk(clk), .rstn(rstn), .cs_n(bus_if.cs_n), .rd_n(bus_if.rd_n), .wr_n(bus_if.wr_n),
		.addr(bus_if.addr), .host_data_oe(bus_if.host_data_oe),
		.dev_data_oe(bus_if.dev_data_oe), .data_level(bus_if.data_level));
	// 50 MHz clock
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// ----
	// shared tasks
	// ----
	task automatic close_out();
		$display("comparisons %0d, mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : close_out
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : check
	// one host request; a done that never comes ends the run
	task automatic access(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		while (req_ready !== 1'b1 && n < 50) begin
			@(negedge clk);
			n++;
		end
		if (req_ready !== 1'b1) begin
			check(32'h0, 32'h1);
			close_out();
		end
		@(posedge clk);
		req_valid <= 1'b1;
		req_write <= wr;
		req_addr  <= a;
		req_wdata <= d;
		@(posedge clk);
		req_valid <= 1'b0;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (done !== 1'b1 && n < 50);
		got_refused = refused;
		if (done !== 1'b1) begin
			check(32'h0, 32'h1);
			close_out();
		end
	endtask : access
	task automatic expect_rd(input logic [7:0] a, input logic [31:0] exp);
		access(1'b0, a, 32'h0);
		check(rdata, exp);
	endtask : expect_rd
	task automatic wait_irq(input logic want, input int bound, output int n);
		n = 0;
		while (irq_seen !== want && n < bound) begin
			@(negedge clk);
			n++;
		end
		check({31'h0, irq_seen}, {31'h0, want});
	endtask : wait_irq
	task automatic pulse(input int b);
		@(posedge clk);
		event_pulse[b] <= 1'b1;
		@(posedge clk);
		event_pulse[b] <= 1'b0;
	endtask : pulse
	// ----
	// scenarios
	// ----
	task automatic reset_values();
		logic [7:0]  off [17] = '{8'h50, 8'h54, 8'h58, 8'h5C, 8'h64, 8'h68, 8'h74, 8'h80, 8'h88,
			8'h8C, 8'h90, 8'hA0, 8'hA4, 8'hA8, 8'hAC, 8'hB0, 8'hB4};
		logic [31:0] val [17] = '{{ID_HI, ID_LO}, 32'h0, 32'h0, 32'h0, 32'h87654321, 32'h48000000,
			32'h00050000, 32'h00001200, 32'h0, 32'h0000FFFF, 32'h0000FFFF, 32'h0, 32'h0, 32'h0,
			32'h0, 32'h0, 32'h0};
		foreach (off[i]) expect_rd(off[i], val[i]);
	endtask : reset_values
	// read-only words ignore writes; reserved places are turned away
	task automatic read_only();
		logic [7:0]  off [3] = '{8'h50, 8'h64, 8'h90};
		logic [31:0] val [3] = '{{ID_HI, ID_LO}, 32'h87654321, 32'h0000FFFF};
		foreach (off[i]) begin
			access(1'b1, off[i], 32'hFFFFFFFF);
			expect_rd(off[i], val[i]);
		end
		access(1'b1, 8'h60, 32'hFFFFFFFF);
		check({31'h0, got_refused}, 32'h1);
		access(1'b1, 8'hB8, 32'hFFFFFFFF);
		check({31'h0, got_refused}, 32'h1);
	endtask : read_only
	task automatic windows();
		access(1'b1, 8'hA4, 32'h80000012);
		access(1'b1, 8'hA8, 32'h12345678);
		access(1'b1, 8'hB0, 32'h80000034);
		access(1'b1, 8'hB4, 32'h000000A5);
		check(mac_command, 32'h80000012);
		check(mac_data, 32'h12345678);
		check(eeprom_command, 32'h80000034);
		check(eeprom_data, 32'h000000A5);
		expect_rd(8'hA8, 32'h12345678);
		expect_rd(8'hB4, 32'h000000A5);
	endtask : windows
	task automatic dropped();
		@(posedge clk);
		frame_dropped <= 1'b1;
		repeat (3) @(posedge clk);
		frame_dropped <= 1'b0;
		expect_rd(8'hA0, 32'h00000003);
	endtask : dropped
	// hold-off: interval 8 units of 4 cycles, then zero, restart, wake, pin gate
	task automatic holdoff();
		int n;
		access(1'b1, 8'h5C, 32'h00020001);
		access(1'b1, 8'h54, 32'h08000100);
		pulse(0);
		wait_irq(1'b1, 6, n);
		expect_rd(8'h54, 32'h08001100);
		access(1'b1, 8'h58, 32'h00000001);
		pulse(0);
		expect_rd(8'h54, 32'h08003100);
		check({31'h0, irq_seen}, 32'h0);
		wait_irq(1'b1, 40, n);
		check(32'(n > 15), 32'h1);
		access(1'b1, 8'h58, 32'h00000001);
		pulse(0);
		check({31'h0, irq_seen}, 32'h0);
		access(1'b1, 8'h54, 32'h00000100);
		wait_irq(1'b1, 4, n);
		expect_rd(8'h54, 32'h00001100);
		access(1'b1, 8'h58, 32'h00000001);
		wait_irq(1'b0, 4, n);
		access(1'b1, 8'h54, 32'h08004100);
		expect_rd(8'h54, 32'h08002100);
		pulse(17);
		wait_irq(1'b1, 4, n);
		check({31'h0, irq_asserted}, 32'h1);
		access(1'b1, 8'h58, 32'h00020001);
		access(1'b1, 8'h54, 32'h00000000);
		pulse(0);
		repeat (4) @(negedge clk);
		check({31'h0, irq_seen}, 32'h0);
		expect_rd(8'h54, 32'h00001000);
		check({31'h0, irq_asserted}, 32'h0);
		// push-pull pin: active low, active high, then driven while idle
		access(1'b1, 8'h54, 32'h00000101);
		wait_irq(1'b1, 4, n);
		check({31'h0, irq_asserted}, 32'h1);
		access(1'b1, 8'h54, 32'h00000111);
		wait_irq(1'b0, 4, n);
		access(1'b1, 8'h54, 32'h00000011);
		wait_irq(1'b1, 4, n);
		check({31'h0, irq_asserted}, 32'h0);
	endtask : holdoff
	// main sequence
	initial begin
		rstn = 1'b0;
		event_pulse = 32'h0;
		frame_dropped = 1'b0;
		req_valid = 1'b0;
		req_write = 1'b0;
		req_addr = 8'h0;
		req_wdata = 32'h0;
		err_total = 0;
		checks_done = 0;
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		reset_values();
		read_only();
		windows();
		dropped();
		holdoff();
		close_out();
	end
endmodule : host_csr_bank_irq_holdoff_test
`default_nettype wire
